// ==== core/ppms_sequencer.sv ====
/*
 * Mode sequencer of a push-pull transformer driver: shutdown, start-up, soft-start,
 * operation and fault, with external sync and tri-state switch outputs.
 * Assumes comparator flags, soft-start done and sync clock are synchronous to CLK_IN.
 */
`timescale 1ns/1ps
`include "ppms_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: Shutdown while filtered enable is low.
// R2: Enable high, supply low: switches inactive.
// R3: Switch only with supply and enable good.
// R4: Enable passes a 5 us glitch filter.
// R5: Undriven enable defaults to shutdown.
// R6: Over-temperature stops switching immediately.
// R7: Resume only after temperature below lower threshold.
// R8: Start-up runs oscillator once conditions met.
// R9: Soft-start on power-up or enable rise.
// R10: Over-current ignored during soft-start.
// R11: Operation after soft-start, fixed frequency.
// R12: Drains tri-stated when disabled or supply low.
// R13: Sync mode divides external clock by two.
// R14: Sync mode sticks; lost clock halts switching.
// R15: No duty control or spread spectrum in sync.
// R16: External clock high-Z until supply up.
// R17: Two complementary 50% phase signals.
// R18: Dead-time with both gates low.
// R19: Dead-time about 70 ns.
// R20: Floating clock input halts switching.
// R21: Mode state machine; faults force switching off.
// R22: Enable filter needs full stable interval.
module ppms_sequencer import ppms_pkg::*; #(
  parameter int OSC_HALF_CYC = `PPMS_OSC_HALF_CYC,
  parameter int SYNC_LOSS_CYC = `PPMS_SYNC_LOSS_CYC,
  parameter int EN_FILTER_CYC = `PPMS_EN_FILTER_CYC,
  parameter int DEAD_CYC = `PPMS_DEADTIME_CYC
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic ENABLE_LOCKOUT_IN,
  input wire logic SUPPLY_OK_IN,
  input wire logic THERMAL_HOT_IN,
  input wire logic THERMAL_COOL_IN,
  input wire logic SOFTSTART_DONE_IN,
  input wire logic OVERCURRENT_TRIP_IN,
  input wire logic CLK_FLOATING_IN,
  input wire logic SYNC_CLK_IN,
  input wire logic SYNC_SELECT_IN,
  input wire logic DUTY_CONTROL_IN,
  input wire logic SPREAD_SPECTRUM_IN,
  output logic SWITCH_DRAIN_A_OUT,
  output logic SWITCH_DRAIN_A_OE_OUT,
  output logic SWITCH_DRAIN_B_OUT,
  output logic SWITCH_DRAIN_B_OE_OUT,
  output logic SOFTSTART_RUN_OUT,
  output logic OSC_RUN_OUT,
  output logic SYNC_MODE_OUT,
  output logic THERMAL_SHUTDOWN_OUT,
  output logic DUTY_CONTROL_ACTIVE_OUT,
  output logic SPREAD_SPECTRUM_ACTIVE_OUT,
  output logic [4:0] MODE_OUT
);
  ppms_state_type state_q, state_d;
  logic en_filt;
  logic en_filt_prev_q, en_filt_prev_d;
  logic tsd_q, tsd_d;
  logic sync_q, sync_d;
  logic sync_lost_q, sync_lost_d;
  logic sclk_prev_q, sclk_prev_d;
  logic [`PPMS_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
  logic [`PPMS_CNT_W-1:0] loss_cnt_q, loss_cnt_d;
  logic tick;
  logic run;
  logic halt;
  logic oc_block;
  // Pin registers
  logic sd_a_q, sd_a_d;
  logic sd_b_q, sd_b_d;
  logic oe_q, oe_d;
  logic ss_q, ss_d;
  logic osc_q, osc_d;
  logic dc_q, dc_d;
  logic ssm_q, ssm_d;

  // Soft-start and operation are the only modes that may drive the gates
  function automatic logic drives_gates(input ppms_state_type mode);
    return (mode == PPMS_SOFTSTART) || (mode == PPMS_OPERATE);
  endfunction : drives_gates

  ppms_phase_if ph ();

  // Raw enable is noisy; nothing below acts on it unfiltered

  ppms_enable_filter #(.FILTER_CYC(EN_FILTER_CYC)) u_filter (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .raw_in(ENABLE_LOCKOUT_IN),
    .filt_out(en_filt)
  );

  // Gate stage owns phase and dead time; this module only grants run and ticks
  ppms_gate_stage #(.DEAD_CYC(DEAD_CYC)) u_gate (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .ph(ph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Thermal latch with hysteresis
  // Hot wins over cool, so a flapping sensor keeps the stage off
  always_comb begin
    tsd_d = tsd_q;
    if (THERMAL_HOT_IN) begin
      tsd_d = 1'b1; // see R6
    end else if (THERMAL_COOL_IN) begin
      tsd_d = 1'b0; // see R7
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync capture and loss detection; only reset (power cycle) leaves sync
  always_comb begin
    sync_d = sync_q;
    sync_lost_d = sync_lost_q;
    sclk_prev_d = SYNC_CLK_IN;
    loss_cnt_d = loss_cnt_q;
    if (SYNC_SELECT_IN) begin
      sync_d = 1'b1; // see R14
    end
    // Loss count runs only in sync mode; the internal oscillator needs no watchdog
    if (sync_q) begin
      if (SYNC_CLK_IN != sclk_prev_q) begin
        loss_cnt_d = '0;
      end else if (loss_cnt_q == `PPMS_CNT_W'(SYNC_LOSS_CYC - 1)) begin
        sync_lost_d = 1'b1; // Sticky until reset, see R14
      end else begin
        loss_cnt_d = loss_cnt_q + `PPMS_CNT_W'(1);
      end
    end
  end

  // Previous sync pin sample feeds both the edge and the loss detectors
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      sync_q <= 1'b0;
      sync_lost_q <= 1'b0;
      loss_cnt_q <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      sync_lost_q <= sync_lost_d;
      loss_cnt_q <= loss_cnt_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator half-period ticks, or sync rising edges
  // Counter restarts whenever the oscillator is off, so the first half period after a start is exact
  always_comb begin
    osc_cnt_d = '0;
    tick = 1'b0;
    if (sync_q) begin
      tick = SYNC_CLK_IN && !sclk_prev_q; // One phase flip per ext edge pair, see R13
    end else if (osc_q) begin
      if (osc_cnt_q == `PPMS_CNT_W'(OSC_HALF_CYC - 1)) begin
        tick = 1'b1;
      end else begin
        osc_cnt_d = osc_cnt_q + `PPMS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    state_d = state_q;
    en_filt_prev_d = en_filt;
    unique case (state_q)
      PPMS_SHUTDOWN: begin
        if (en_filt) begin
          state_d = PPMS_STARTUP; // see R1
        end
      end
      PPMS_STARTUP: begin
        if (!en_filt) begin
          state_d = PPMS_SHUTDOWN;
        end else if (SUPPLY_OK_IN && !tsd_q) begin
          state_d = PPMS_SOFTSTART; // see R2 see R8
        end
      end
      PPMS_SOFTSTART: begin
        if (!en_filt || !SUPPLY_OK_IN) begin
          state_d = en_filt ? PPMS_STARTUP : PPMS_SHUTDOWN;
        end else if (tsd_q) begin
          state_d = PPMS_FAULT;
        end else if (SOFTSTART_DONE_IN) begin
          state_d = PPMS_OPERATE; // see R11
        end
      end
      PPMS_OPERATE: begin
        if (!en_filt || !SUPPLY_OK_IN) begin
          state_d = en_filt ? PPMS_STARTUP : PPMS_SHUTDOWN;
        end else if (tsd_q) begin
          state_d = PPMS_FAULT; // see R21
        end
      end
      // Fault clears only through start-up, so soft-start always reruns
      PPMS_FAULT: begin
        if (!en_filt) begin
          state_d = PPMS_SHUTDOWN;
        end else if (!tsd_q) begin
          state_d = PPMS_STARTUP; // Restart via soft-start, see R7
        end
      end
      default: state_d = PPMS_SHUTDOWN;
    endcase
    if (en_filt && !en_filt_prev_q && state_q != PPMS_SHUTDOWN) begin
      state_d = PPMS_STARTUP; // Enable rise reruns soft-start, see R9
    end
  end

  // Previous enable resets low like the filter, else reset looks like a rise
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      state_q <= PPMS_SHUTDOWN;
      en_filt_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      en_filt_prev_q <= en_filt_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching permission and outputs
  // Over-current only acts once operating; ignored in soft-start
  assign oc_block = (state_q == PPMS_OPERATE) && OVERCURRENT_TRIP_IN; // see R10
  assign halt = tsd_q || THERMAL_HOT_IN || CLK_FLOATING_IN || (sync_q && sync_lost_q); // see R6 see R20
  assign run = drives_gates(state_q) && en_filt && SUPPLY_OK_IN && !halt; // see R3
  assign ph.run = run && !oc_block;
  assign ph.tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers
  always_comb begin
    // Gates masked by run, so a fault bites at the very next edge
    sd_a_d = ph.gate_a && ph.run;
    sd_b_d = ph.gate_b && ph.run;
    oe_d = en_filt && SUPPLY_OK_IN; // Tri-state when off, see R12
    ss_d = (state_d == PPMS_SOFTSTART); // see R9
    osc_d = drives_gates(state_d); // see R8
    dc_d = DUTY_CONTROL_IN && !sync_d; // see R15
    ssm_d = SPREAD_SPECTRUM_IN && !sync_d; // see R15
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      sd_a_q <= 1'b0;
      sd_b_q <= 1'b0;
      oe_q <= 1'b0;
      ss_q <= 1'b0;
      osc_q <= 1'b0;
      dc_q <= 1'b0;
      ssm_q <= 1'b0;
    end else begin
      sd_a_q <= sd_a_d;
      sd_b_q <= sd_b_d;
      oe_q <= oe_d;
      ss_q <= ss_d;
      osc_q <= osc_d;
      dc_q <= dc_d;
      ssm_q <= ssm_d;
    end
  end

  assign SWITCH_DRAIN_A_OUT = sd_a_q;
  assign SWITCH_DRAIN_B_OUT = sd_b_q;
  assign SWITCH_DRAIN_A_OE_OUT = oe_q;
  assign SWITCH_DRAIN_B_OE_OUT = oe_q;
  assign SOFTSTART_RUN_OUT = ss_q;
  assign OSC_RUN_OUT = osc_q;
  assign SYNC_MODE_OUT = sync_q;
  assign THERMAL_SHUTDOWN_OUT = tsd_q;
  assign DUTY_CONTROL_ACTIVE_OUT = dc_q;
  assign SPREAD_SPECTRUM_ACTIVE_OUT = ssm_q;
  assign MODE_OUT = state_q;
endmodule : ppms_sequencer

// ==== include/ppms_defines.svh ====
/*
 * Constants of the push-pull mode sequencer: timing figures and derived counts.
 * Assumes a single 125 MHz clock; included by bare name.
 */
`ifndef PPMS_DEFINES_SVH
`define PPMS_DEFINES_SVH

`define PPMS_CLK_MHZ 125
`define PPMS_EN_FILTER_NS 5000
`define PPMS_EN_FILTER_CYC ((`PPMS_EN_FILTER_NS * `PPMS_CLK_MHZ + 999) / 1000)
`define PPMS_DEADTIME_NS 70
`define PPMS_DEADTIME_CYC ((`PPMS_DEADTIME_NS * `PPMS_CLK_MHZ + 999) / 1000)
`define PPMS_OSC_HALF_CYC 63
`define PPMS_SYNC_LOSS_CYC 250
`define PPMS_CNT_W 16

`endif

// ==== include/ppms_pkg.sv ====
/*
 * Types of the push-pull mode sequencer.
 * Assumes ppms_defines.svh is available on the include path.
 */
package ppms_pkg;
  typedef enum logic [4:0] {
    PPMS_SHUTDOWN = 5'h01,
    PPMS_STARTUP = 5'h02,
    PPMS_SOFTSTART = 5'h04,
    PPMS_OPERATE = 5'h08,
    PPMS_FAULT = 5'h10
  } ppms_state_type;
endpackage : ppms_pkg

// ==== include/ppms_phase_if.sv ====
/*
 * Interface carrying the phase request and gate results between the sequencer and the gate stage.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface ppms_phase_if;
  logic run;
  logic tick;
  logic gate_a;
  logic gate_b;
  modport ctrl (output run, output tick, input gate_a, input gate_b);
  modport gate (input run, input tick, output gate_a, output gate_b);
endinterface : ppms_phase_if

// ==== core/ppms_enable_filter.sv ====
/*
 * Glitch filter for the enable comparator: output changes after a stable interval.
 * Assumes the input is synchronous to the clock.
 */
`timescale 1ns/1ps
`include "ppms_defines.svh"
module ppms_enable_filter import ppms_pkg::*; #(
  parameter int FILTER_CYC = `PPMS_EN_FILTER_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic raw_in,
  output logic filt_out
);
  logic [`PPMS_CNT_W-1:0] cnt_q, cnt_d;
  logic filt_q, filt_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_d = '0;
    filt_d = filt_q;
    if (raw_in != filt_q) begin
      if (cnt_q == `PPMS_CNT_W'(FILTER_CYC - 1)) begin // see R4 see R22
        filt_d = raw_in;
      end else begin
        cnt_d = cnt_q + `PPMS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      filt_q <= 1'b0; // Floating pin reads as off, see R5
    end else begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end
  assign filt_out = filt_q;
endmodule : ppms_enable_filter

// ==== core/ppms_gate_stage.sv ====
/*
 * Divide-by-two phase generator with break-before-make dead time.
 * Assumes tick pulses mark oscillator edges; run low forces both gates low at once.
 */
`timescale 1ns/1ps
`include "ppms_defines.svh"
module ppms_gate_stage import ppms_pkg::*; #(
  parameter int DEAD_CYC = `PPMS_DEADTIME_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  ppms_phase_if.gate ph
);
  logic phase_q, phase_d;
  logic [7:0] dead_q, dead_d;
  logic ga_q, ga_d, gb_q, gb_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    phase_d = phase_q;
    dead_d = dead_q;
    ga_d = ga_q;
    gb_d = gb_q;
    if (!ph.run) begin
      phase_d = 1'b0;
      dead_d = 8'(DEAD_CYC);
      ga_d = 1'b0;
      gb_d = 1'b0;
    end else if (ph.tick) begin
      phase_d = ~phase_q; // 50% complementary phases, see R17 see R13
      dead_d = 8'(DEAD_CYC);
      ga_d = 1'b0; // Both low first, see R18
      gb_d = 1'b0;
    end else if (dead_q != 8'h00) begin
      dead_d = dead_q - 8'h01; // see R19
    end else begin
      ga_d = phase_q;
      gb_d = ~phase_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      phase_q <= 1'b0;
      dead_q <= 8'(DEAD_CYC);
      ga_q <= 1'b0;
      gb_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      dead_q <= dead_d;
      ga_q <= ga_d;
      gb_q <= gb_d;
    end
  end
  assign ph.gate_a = ga_q;
  assign ph.gate_b = gb_q;
endmodule : ppms_gate_stage

// ==== tb/ppms_seq_assertions.sv ====
/* Port checker of the mode sequencer.
   Assumes a bind to ppms_sequencer and one clock. */
`timescale 1ns/1ps
module ppms_seq_assertions (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic ENABLE_LOCKOUT_IN,
  input wire logic SUPPLY_OK_IN,
  input wire logic THERMAL_HOT_IN,
  input wire logic THERMAL_COOL_IN,
  input wire logic OVERCURRENT_TRIP_IN,
  input wire logic SWITCH_DRAIN_A_OUT,
  input wire logic SWITCH_DRAIN_A_OE_OUT,
  input wire logic SWITCH_DRAIN_B_OUT,
  input wire logic SWITCH_DRAIN_B_OE_OUT,
  input wire logic OSC_RUN_OUT,
  input wire logic SYNC_MODE_OUT,
  input wire logic THERMAL_SHUTDOWN_OUT,
  input wire logic DUTY_CONTROL_ACTIVE_OUT,
  input wire logic SPREAD_SPECTRUM_ACTIVE_OUT,
  input wire logic [4:0] MODE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  AST_NO_OVERLAP: assert property (!(SWITCH_DRAIN_A_OUT && SWITCH_DRAIN_B_OUT))
    else $error("Both gates high");
  AST_DEAD_AB: assert property ($fell(SWITCH_DRAIN_A_OUT) |-> !SWITCH_DRAIN_B_OUT [*8])
    else $error("Gate b rose inside dead time");
  AST_DEAD_BA: assert property ($fell(SWITCH_DRAIN_B_OUT) |-> !SWITCH_DRAIN_A_OUT [*8])
    else $error("Gate a rose inside dead time");
  AST_SHUTDOWN_IDLE: assert property ((MODE_OUT == 5'h01) [*3] |-> !OSC_RUN_OUT && !SWITCH_DRAIN_A_OUT)
    else $error("Activity in shutdown");
  AST_SUPPLY_TRISTATE: assert property (!SUPPLY_OK_IN [*3] |-> !SWITCH_DRAIN_A_OE_OUT && !SWITCH_DRAIN_B_OE_OUT)
    else $error("Drains driven with supply low");
  AST_FILTER: assert property (MODE_OUT == 5'h02 && $past(MODE_OUT) == 5'h01
    |-> $past(ENABLE_LOCKOUT_IN, 3) && $past(ENABLE_LOCKOUT_IN, 4)) else $error("Start-up without stable enable");
  AST_HOT_STOP: assert property (THERMAL_HOT_IN |-> ##[1:2] !SWITCH_DRAIN_A_OUT && !SWITCH_DRAIN_B_OUT)
    else $error("Switching while hot");
  AST_THERMAL_HOLD: assert property (THERMAL_SHUTDOWN_OUT && !THERMAL_COOL_IN |=> THERMAL_SHUTDOWN_OUT)
    else $error("Thermal latch left early");
  AST_OC_STOP: assert property ((MODE_OUT == 5'h08 && OVERCURRENT_TRIP_IN) [*3]
    |-> !SWITCH_DRAIN_A_OUT && !SWITCH_DRAIN_B_OUT) else $error("Switching past current trip");
  AST_SYNC_STICKY: assert property (SYNC_MODE_OUT |=> SYNC_MODE_OUT)
    else $error("Sync mode dropped");
  AST_SYNC_PLAIN: assert property (SYNC_MODE_OUT [*2] |-> !DUTY_CONTROL_ACTIVE_OUT && !SPREAD_SPECTRUM_ACTIVE_OUT)
    else $error("Duty or spread active in sync");
endmodule : ppms_seq_assertions

// ==== tb/ppms_power_stage_model.sv ====
/* Power stage and external sync source beside the sequencer.
   Assumes the sequencer clock; counts driven gate pulses. */
`timescale 1ns/1ps
module ppms_power_stage_model (
  input wire logic clk_in,
  input wire logic supply_ok_in,
  input wire logic sync_sel_in,
  input wire logic sync_run_in,
  input wire logic drain_a_in,
  input wire logic drain_a_oe_in,
  input wire logic drain_b_in,
  input wire logic drain_b_oe_in,
  output logic sync_clk_out = 1'b0,
  output logic clk_floating_out,
  output logic [15:0] a_rises_out = 16'h0,
  output logic [15:0] b_rises_out = 16'h0
);
  logic [3:0] div_q = 4'h0;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  // Open pin once sync is chosen but the source is gone
  assign clk_floating_out = sync_sel_in && !sync_run_in;
  always @(posedge clk_in) begin
    // Source stays quiet until the supply is up
    if (!(sync_run_in && supply_ok_in)) begin
      div_q <= 4'h0;
      sync_clk_out <= 1'b0;
    end else if (div_q == 4'he) begin
      div_q <= 4'h0;
      sync_clk_out <= !sync_clk_out;
    end else begin
      div_q <= div_q + 4'h1;
    end
    // Undriven drains do not switch the primary
    a_q <= drain_a_in && drain_a_oe_in;
    b_q <= drain_b_in && drain_b_oe_in;
    if (drain_a_in && drain_a_oe_in && !a_q) a_rises_out <= a_rises_out + 16'h1;
    if (drain_b_in && drain_b_oe_in && !b_q) b_rises_out <= b_rises_out + 16'h1;
  end
endmodule : ppms_power_stage_model

// ==== tb/ppms_sequencer_tb_top.sv ====
/* Self-checking bench of the mode sequencer.
   Assumes the power stage model and the port checker. */
`timescale 1ns/1ps
module ppms_sequencer_tb_top import ppms_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, sup = 1'b0, hot = 1'b0, cool = 1'b0, ssd = 1'b0;
  logic oc = 1'b0, ssel = 1'b0, run = 1'b0, duty = 1'b0, spr = 1'b0;
  logic sclk, flt, a, aoe, b, boe, ssr, osc, sm, thermal_shutdown, dact, sact;
  logic [4:0] mode;
  logic [15:0] na, nb, pa;
  int miscompares = 0;
  int n_tests = 0;
  initial forever #4 clk = ~clk;
  // Short counts keep the run brief; dead time stays at full length
  ppms_sequencer #(.OSC_HALF_CYC(20), .SYNC_LOSS_CYC(40), .EN_FILTER_CYC(4), .DEAD_CYC(9)) DUT (
    .CLK_IN(clk), .RSTN_IN(rstn), .ENABLE_LOCKOUT_IN(en), .SUPPLY_OK_IN(sup), .THERMAL_HOT_IN(hot),
    .THERMAL_COOL_IN(cool), .SOFTSTART_DONE_IN(ssd), .OVERCURRENT_TRIP_IN(oc), .CLK_FLOATING_IN(flt),
    .SYNC_CLK_IN(sclk), .SYNC_SELECT_IN(ssel), .DUTY_CONTROL_IN(duty), .SPREAD_SPECTRUM_IN(spr),
    .SWITCH_DRAIN_A_OUT(a), .SWITCH_DRAIN_A_OE_OUT(aoe), .SWITCH_DRAIN_B_OUT(b), .SWITCH_DRAIN_B_OE_OUT(boe),
    .SOFTSTART_RUN_OUT(ssr), .OSC_RUN_OUT(osc), .SYNC_MODE_OUT(sm), .THERMAL_SHUTDOWN_OUT(thermal_shutdown),
    .DUTY_CONTROL_ACTIVE_OUT(dact), .SPREAD_SPECTRUM_ACTIVE_OUT(sact), .MODE_OUT(mode));
  ppms_power_stage_model PS (.clk_in(clk), .supply_ok_in(sup), .sync_sel_in(ssel), .sync_run_in(run),
    .drain_a_in(a), .drain_a_oe_in(aoe), .drain_b_in(b), .drain_b_oe_in(boe), .sync_clk_out(sclk),
    .clk_floating_out(flt), .a_rises_out(na), .b_rises_out(nb));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic wait_mode(input logic [4:0] m);
    repeat (50) if (mode !== m) @(negedge clk);
    chk(mode, m);
    if (mode !== m) close_out();
  endtask : wait_mode
  task automatic t_idle_glitch;
    cyc(30);
    chk({aoe, boe, osc, mode}, PPMS_SHUTDOWN);
    en = 1'b1;
    cyc(3);
    en = 1'b0;
    cyc(20);
    chk(mode, PPMS_SHUTDOWN);
    $display("idle and glitch done");
  endtask : t_idle_glitch
  task automatic t_start;
    en = 1'b1;
    wait_mode(PPMS_STARTUP);
    cyc(20);
    chk({aoe, boe, a, b}, 4'h0);
    sup = 1'b1;
    wait_mode(PPMS_SOFTSTART);
    cyc(3);
    chk({osc, ssr}, 2'h3);
    oc = 1'b1;
    pa = na;
    cyc(200);
    chk(na - pa > 16'h3, 1'b1);
    oc = 1'b0;
    ssd = 1'b1;
    duty = 1'b1;
    spr = 1'b1;
    wait_mode(PPMS_OPERATE);
    cyc(3);
    chk({aoe, boe, dact, sact}, 4'hf);
    pa = na;
    cyc(400);
    chk(na - pa, 16'ha);
    chk(na - nb + 16'h1 < 16'h3, 1'b1);
    oc = 1'b1;
    cyc(5);
    pa = na;
    cyc(100);
    chk(na, pa);
    oc = 1'b0;
    $display("start-up done");
  endtask : t_start
  task automatic t_thermal;
    hot = 1'b1;
    cyc(3);
    chk({a, b, thermal_shutdown}, 3'h1);
    wait_mode(PPMS_FAULT);
    hot = 1'b0;
    cyc(30);
    chk(mode, PPMS_FAULT);
    cool = 1'b1;
    wait_mode(PPMS_OPERATE);
    cool = 1'b0;
    $display("thermal done");
  endtask : t_thermal
  task automatic t_sync;
    ssel = 1'b1;
    run = 1'b1;
    cyc(60);
    chk({sm, dact, sact}, 3'h4);
    pa = na;
    cyc(600);
    chk(na - pa, 16'ha);
    run = 1'b0;
    cyc(100);
    pa = na;
    cyc(200);
    chk(na, pa);
    run = 1'b1;
    cyc(60);
    pa = na;
    cyc(200);
    chk(na, pa);
    chk(sm, 1'b1);
    $display("sync done");
  endtask : t_sync
  task automatic t_off;
    sup = 1'b0;
    cyc(5);
    chk({aoe, boe}, 2'h0);
    en = 1'b0;
    wait_mode(PPMS_SHUTDOWN);
    $display("shutdown done");
  endtask : t_off
  initial begin
    cyc(5);
    rstn = 1'b1;
    t_idle_glitch();
    t_start();
    t_thermal();
    t_sync();
    t_off();
    close_out();
  end
endmodule : ppms_sequencer_tb_top
bind ppms_sequencer ppms_seq_assertions CHK (.*);
